/* File: logic/sdvc_pkg.sv */
// Package of constants, register layouts and types for the synth divider and calibration block
package sdvc_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] ADDR_COMMIT = 12'h00f;
    localparam logic [ADDR_W-1:0] ADDR_FB_A = 12'h201;
    localparam logic [ADDR_W-1:0] ADDR_CAL = 12'h203;
    localparam logic [ADDR_W-1:0] ADDR_FB_B = 12'h204;
    localparam logic [ADDR_W-1:0] ADDR_LF = 12'h205;
    localparam logic [ADDR_W-1:0] ADDR_FB_C = 12'h207;
    localparam logic [ADDR_W-1:0] ADDR_FB_D = 12'h208;
    localparam logic [ADDR_W-1:0] ADDR_SYNC = 12'h32a;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 12'h509;

    // ------------------------------------------------------------
    // Divider limits and timing
    // ------------------------------------------------------------
    localparam int NUM_CH = 14;
    localparam logic [4:0] R1_MIN = 5'h01;
    localparam logic [2:0] M1_MIN = 3'h3;
    localparam logic [2:0] M1_MAX = 3'h5;
    localparam logic [5:0] B_MIN = 6'h03;
    localparam logic [1:0] PRESCALE_SHIFT = 2'h2;
    localparam logic [8:0] CAL_DIV_MIN = 9'h010;
    localparam logic [2:0] CPOLE1_MAX = 3'h6;
    localparam int CAL_CNT_W = 19;
    localparam int CAL_PFD_PERIODS_DEF = 400000;

    // ------------------------------------------------------------
    // Register layouts
    // ------------------------------------------------------------
    typedef struct packed {logic [6:0] rsvd; logic flag;} sdvc_bit0_t;
    typedef struct packed {logic [2:0] rsvd; logic [4:0] r1;} sdvc_fb_a_t;
    typedef struct packed {logic [1:0] a_cnt; logic [5:0] b_cnt;} sdvc_fb_c_t;
    typedef struct packed {logic [4:0] rsvd; logic [2:0] m1;} sdvc_fb_d_t;
    typedef struct packed {
        logic [1:0] rpole2;
        logic [2:0] cpole1;
        logic [2:0] rzero;
    } sdvc_lf_t;
    typedef struct packed {
        logic [4:0] rsvd;
        logic cal_path;
        logic first_done;
        logic busy;
    } sdvc_status_t;

    // ------------------------------------------------------------
    // Configuration, channel and state types
    // ------------------------------------------------------------
    typedef struct packed {
        sdvc_fb_a_t fb_a;
        logic [7:0] n2;
        sdvc_fb_c_t fb_c;
        sdvc_fb_d_t fb_d;
        sdvc_lf_t lf;
        logic cal;
    } sdvc_cfg_t;

    typedef enum logic [1:0] {SRC_CLEANUP, SRC_SYNTH, SRC_SYSREF} sdvc_src_t;

    typedef struct packed {
        sdvc_src_t src;
        logic use_div;
        logic sysref_retime;
        logic [7:0] div;
    } sdvc_ch_cfg_t;

    typedef enum logic {CAL_IDLE, CAL_RUN} sdvc_cal_state_t;

endpackage : sdvc_pkg

/* File: logic/sdvc_cal_divider.sv */
// Calibration-only feedback divider: prescaler of four times main count plus swallow count
`timescale 1ns/1ps
module sdvc_cal_divider
    import sdvc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic enable,
    input wire logic [5:0] b_cnt,
    input wire logic [1:0] a_cnt,
    output logic tick
);

    typedef struct packed {
        logic [8:0] cnt;
        logic tick;
    } sdvc_cdiv_t;

    sdvc_cdiv_t s_q;
    sdvc_cdiv_t s_d;
    logic [5:0] b_eff;
    logic [8:0] total;

    always_comb begin
        // Main count below its floor is lifted so the ratio stays legal
        b_eff = (b_cnt < B_MIN) ? B_MIN : b_cnt;
        total = 9'({3'h0, b_eff} << PRESCALE_SHIFT) + 9'({7'h0, a_cnt});
        if (total < CAL_DIV_MIN) begin
            total = CAL_DIV_MIN;
        end
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!enable) begin
            s_d.cnt = '0;
        end else if (s_q.cnt >= total - 9'h001) begin
            s_d.cnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 9'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;

endmodule : sdvc_cal_divider

/* File: logic/sdvc_top.sv */
// Synthesizer divider, VCO calibration sequencer and output channel sync control
// Function
// - Reference predivider divides by one to thirty-one
// - Normal feedback is integer divider times output divider
// - Calibration divider is four times main plus swallow
// - Calibration path only used while calibration runs
// - VCO output divider supports three, four, five
// - Calibration starts on rising calibrate bit
// - Status busy flag set during calibration only
// - Calibration completion issues an output sync
// - Synth-sourced channels held until first calibration
// - Calibration lasts four hundred thousand PFD periods
// - Fourteen channels, selectable source, 8-bit divider
// - Coarse delay only with channel divider path
// - Sync resets dividers of divider-path channels only, except SYSREF channels without retime
// - Fine delay available on every channel
// - Loop filter selects eight, seven, four values
// - Sync happens on falling edge of sync bit
`timescale 1ns/1ps
module sdvc_top
    import sdvc_pkg::*;
#(
    parameter int CAL_PFD_PERIODS = CAL_PFD_PERIODS_DEF
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [7:0] reg_rdata,
    input wire sdvc_ch_cfg_t [NUM_CH-1:0] ch_cfg,
    output logic pfd_tick,
    output logic fb_tick,
    output logic cal_path_sel,
    output logic cal_busy,
    output logic sync_event,
    output logic [2:0] lf_rzero,
    output logic [2:0] lf_cpole1,
    output logic [1:0] lf_rpole2,
    output logic [NUM_CH-1:0] ch_pulse,
    output logic [NUM_CH-1:0] ch_held,
    output logic [NUM_CH-1:0] ch_coarse_ok,
    output logic [NUM_CH-1:0] ch_sync_ok,
    output logic [NUM_CH-1:0] ch_fine_ok
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    localparam logic [CAL_CNT_W-1:0] CAL_LAST = CAL_CNT_W'(CAL_PFD_PERIODS - 1);

    typedef struct packed {
        sdvc_cfg_t stg;
        sdvc_cfg_t act;
        logic sync_bit;
        logic [4:0] ref_cnt;
        logic [2:0] m1_cnt;
        logic [7:0] n2_cnt;
        sdvc_cal_state_t cal_state;
        logic [CAL_CNT_W-1:0] cal_cnt;
        logic cal_arm;
        logic cal_sel;
        logic first_done;
        logic pfd_tick;
        logic fb_tick;
        logic sync_event;
        logic [NUM_CH-1:0][7:0] ch_cnt;
        logic [NUM_CH-1:0] ch_pulse;
        logic [NUM_CH-1:0] ch_held;
        logic [NUM_CH-1:0] ch_coarse_ok;
        logic [NUM_CH-1:0] ch_sync_ok;
        logic [NUM_CH-1:0] ch_fine_ok;
        logic [7:0] rdata;
    } sdvc_state_t;

    sdvc_state_t s_q;
    sdvc_state_t s_d;
    logic cal_div_tick;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Wrap compare for dividers where a zero setting means full range
    function automatic logic at_wrap(input logic [7:0] cnt, input logic [7:0] div);
        at_wrap = (cnt == 8'(div - 8'h01));
    endfunction : at_wrap

    function automatic logic [2:0] m1_clamp(input logic [2:0] m1);
        if (m1 < M1_MIN) begin
            m1_clamp = M1_MIN;
        end else if (m1 > M1_MAX) begin
            m1_clamp = M1_MAX;
        end else begin
            m1_clamp = m1;
        end
    endfunction : m1_clamp

    // ------------------------------------------------------------
    // Calibration feedback divider
    // ------------------------------------------------------------
    sdvc_cal_divider u_cal_div (
        .clk(clk),
        .resetn(resetn),
        .enable(s_q.cal_sel),
        .b_cnt(s_q.act.fb_c.b_cnt),
        .a_cnt(s_q.act.fb_c.a_cnt),
        .tick(cal_div_tick)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [4:0] r1_eff;
        logic [2:0] m1_eff;
        logic commit;
        logic sync_req;
        logic cal_done;
        sdvc_bit0_t wbit;
        sdvc_status_t stat;
        r1_eff = '0;
        m1_eff = '0;
        commit = 1'b0;
        sync_req = 1'b0;
        cal_done = 1'b0;
        wbit = sdvc_bit0_t'(reg_wdata);
        stat = '0;

        s_d = s_q;
        s_d.pfd_tick = 1'b0;
        s_d.fb_tick = 1'b0;
        s_d.sync_event = 1'b0;

        // Register writes other than commit and sync land in the staged copy
        if (reg_we) begin
            if (reg_addr == ADDR_COMMIT) begin
                commit = wbit.flag;
            end else if (reg_addr == ADDR_FB_A) begin
                s_d.stg.fb_a = sdvc_fb_a_t'(reg_wdata);
            end else if (reg_addr == ADDR_CAL) begin
                s_d.stg.cal = wbit.flag;
            end else if (reg_addr == ADDR_FB_B) begin
                s_d.stg.n2 = reg_wdata;
            end else if (reg_addr == ADDR_LF) begin
                s_d.stg.lf = sdvc_lf_t'(reg_wdata);
            end else if (reg_addr == ADDR_FB_C) begin
                s_d.stg.fb_c = sdvc_fb_c_t'(reg_wdata);
            end else if (reg_addr == ADDR_FB_D) begin
                s_d.stg.fb_d = sdvc_fb_d_t'(reg_wdata);
            end else if (reg_addr == ADDR_SYNC) begin
                s_d.sync_bit = wbit.flag;
            end
        end

        // The commit pulse copies the staged settings in one step
        if (commit) begin
            s_d.act = s_d.stg;
            // Seven capacitor choices only; the eighth code folds onto the last
            if (s_d.act.lf.cpole1 > CPOLE1_MAX) begin
                s_d.act.lf.cpole1 = CPOLE1_MAX;
            end
        end

        // The pre-divider floor keeps a zero setting from stalling the PFD
        r1_eff = (s_q.act.fb_a.r1 < R1_MIN) ? R1_MIN : s_q.act.fb_a.r1;
        if (s_q.ref_cnt >= r1_eff - 5'h01) begin
            s_d.ref_cnt = '0;
            s_d.pfd_tick = 1'b1;
        end else begin
            s_d.ref_cnt = s_q.ref_cnt + 5'h01;
        end

        // ------------------------------------------------------------
        // Feedback path
        // ------------------------------------------------------------
        m1_eff = m1_clamp(s_q.act.fb_d.m1);
        if (s_q.cal_sel) begin
            s_d.m1_cnt = '0;
            s_d.n2_cnt = '0;
            s_d.fb_tick = cal_div_tick;
        end else if (s_q.m1_cnt >= m1_eff - 3'h1) begin
            s_d.m1_cnt = '0;
            if (at_wrap(s_q.n2_cnt, s_q.act.n2)) begin
                s_d.n2_cnt = '0;
                s_d.fb_tick = 1'b1;
            end else begin
                s_d.n2_cnt = s_q.n2_cnt + 8'h01;
            end
        end else begin
            s_d.m1_cnt = s_q.m1_cnt + 3'h1;
        end

        // ------------------------------------------------------------
        // Calibration sequencer
        // ------------------------------------------------------------
        // Holding the bit high never restarts; it must be seen low first
        if (!s_q.act.cal) begin
            s_d.cal_arm = 1'b1;
        end
        case (s_q.cal_state)
            CAL_IDLE: begin
                s_d.cal_sel = 1'b0;
                if (s_q.act.cal && s_q.cal_arm) begin
                    s_d.cal_state = CAL_RUN;
                    s_d.cal_arm = 1'b0;
                    s_d.cal_cnt = '0;
                    s_d.cal_sel = 1'b1;
                end
            end
            CAL_RUN: begin
                if (s_q.pfd_tick) begin
                    if (s_q.cal_cnt == CAL_LAST) begin
                        cal_done = 1'b1;
                    end else begin
                        s_d.cal_cnt = s_q.cal_cnt + CAL_CNT_W'(1);
                    end
                end
                if (cal_done) begin
                    s_d.cal_state = CAL_IDLE;
                    s_d.cal_sel = 1'b0;
                    s_d.first_done = 1'b1;
                end
            end
            default: begin
                s_d.cal_state = CAL_IDLE;
                s_d.cal_sel = 1'b0;
            end
        endcase

        // ------------------------------------------------------------
        // Output sync
        // ------------------------------------------------------------
        // A falling sync bit or a finished calibration resets the dividers of sync-enabled channels
        sync_req = (s_q.sync_bit && !s_d.sync_bit) || cal_done;
        s_d.sync_event = sync_req;

        for (int i = 0; i < NUM_CH; i++) begin
            s_d.ch_fine_ok[i] = 1'b1;
            s_d.ch_coarse_ok[i] = ch_cfg[i].use_div &&
                (ch_cfg[i].src != SRC_SYSREF || ch_cfg[i].sysref_retime);
            s_d.ch_sync_ok[i] = s_d.ch_coarse_ok[i];
            // Outputs stay quiet while the sync bit is up
            s_d.ch_held[i] = s_d.sync_bit ||
                (ch_cfg[i].src == SRC_SYNTH && !s_d.first_done);
            s_d.ch_pulse[i] = 1'b0;
            if (sync_req && s_d.ch_sync_ok[i]) begin
                s_d.ch_cnt[i] = '0;
            end else if (!ch_cfg[i].use_div) begin
                s_d.ch_cnt[i] = '0;
                s_d.ch_pulse[i] = !s_d.ch_held[i];
            end else if (at_wrap(s_q.ch_cnt[i], ch_cfg[i].div)) begin
                s_d.ch_cnt[i] = '0;
                s_d.ch_pulse[i] = !s_d.ch_held[i];
            end else begin
                s_d.ch_cnt[i] = s_q.ch_cnt[i] + 8'h01;
            end
        end

        // ------------------------------------------------------------
        // Register reads
        // ------------------------------------------------------------
        stat.busy = (s_q.cal_state == CAL_RUN);
        stat.first_done = s_q.first_done;
        stat.cal_path = s_q.cal_sel;
        if (reg_re) begin
            if (reg_addr == ADDR_FB_A) begin
                s_d.rdata = 8'(s_q.stg.fb_a);
            end else if (reg_addr == ADDR_CAL) begin
                s_d.rdata = {7'h00, s_q.stg.cal};
            end else if (reg_addr == ADDR_FB_B) begin
                s_d.rdata = s_q.stg.n2;
            end else if (reg_addr == ADDR_LF) begin
                s_d.rdata = 8'(s_q.stg.lf);
            end else if (reg_addr == ADDR_FB_C) begin
                s_d.rdata = 8'(s_q.stg.fb_c);
            end else if (reg_addr == ADDR_FB_D) begin
                s_d.rdata = 8'(s_q.stg.fb_d);
            end else if (reg_addr == ADDR_SYNC) begin
                s_d.rdata = {7'h00, s_q.sync_bit};
            end else if (reg_addr == ADDR_STAT) begin
                s_d.rdata = 8'(stat);
            end else begin
                // Commit bit self-clears, so it reads zero like unmapped space
                s_d.rdata = 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata = s_q.rdata;
    assign pfd_tick = s_q.pfd_tick;
    assign fb_tick = s_q.fb_tick;
    assign cal_path_sel = s_q.cal_sel;
    assign cal_busy = (s_q.cal_state == CAL_RUN);
    assign sync_event = s_q.sync_event;
    assign lf_rzero = s_q.act.lf.rzero;
    assign lf_cpole1 = s_q.act.lf.cpole1;
    assign lf_rpole2 = s_q.act.lf.rpole2;
    assign ch_pulse = s_q.ch_pulse;
    assign ch_held = s_q.ch_held;
    assign ch_coarse_ok = s_q.ch_coarse_ok;
    assign ch_sync_ok = s_q.ch_sync_ok;
    assign ch_fine_ok = s_q.ch_fine_ok;

endmodule : sdvc_top

/* File: testbench/sdvc_top_asserts.sv */
// Port-level assertions for the synth divider and calibration block
`timescale 1ns/1ps
module sdvc_top_asserts
    import sdvc_pkg::*;
#(
    parameter int CAL_PFD_PERIODS = CAL_PFD_PERIODS_DEF
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    input wire logic [7:0] reg_rdata,
    input wire sdvc_ch_cfg_t [NUM_CH-1:0] ch_cfg,
    input wire logic pfd_tick,
    input wire logic fb_tick,
    input wire logic cal_path_sel,
    input wire logic cal_busy,
    input wire logic sync_event,
    input wire logic [2:0] lf_rzero,
    input wire logic [2:0] lf_cpole1,
    input wire logic [1:0] lf_rpole2,
    input wire logic [NUM_CH-1:0] ch_pulse,
    input wire logic [NUM_CH-1:0] ch_held,
    input wire logic [NUM_CH-1:0] ch_coarse_ok,
    input wire logic [NUM_CH-1:0] ch_sync_ok,
    input wire logic [NUM_CH-1:0] ch_fine_ok
);
    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    logic [NUM_CH-1:0] route_ok;
    logic [NUM_CH-1:0] synth_src;
    logic busy_q;
    logic done_q;
    logic [CAL_CNT_W-1:0] tick_cnt_q;

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            route_ok[i] = ch_cfg[i].use_div &&
                (ch_cfg[i].src != SRC_SYSREF || ch_cfg[i].sysref_retime);
            synth_src[i] = (ch_cfg[i].src == SRC_SYNTH);
        end
    end

    // One tick of slack: the last tick may land on the edge that ends the run
    always_ff @(posedge clk) begin
        if (!resetn) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            tick_cnt_q <= '0;
        end else begin
            busy_q <= cal_busy;
            done_q <= done_q | (busy_q & ~cal_busy);
            tick_cnt_q <= cal_busy ? tick_cnt_q + CAL_CNT_W'(pfd_tick) : '0;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_cal_start;
        !cal_busy ##1 cal_busy;
    endsequence
    sequence s_cal_end;
        cal_busy ##1 !cal_busy;
    endsequence

    property p_path_in_cal; cal_path_sel |-> cal_busy; endproperty
    a_path_in_cal: assert property (p_path_in_cal) else $error("cal path outside cal");
    property p_start_path; s_cal_start |-> cal_path_sel && !sync_event; endproperty
    a_start_path: assert property (p_start_path) else $error("cal start without path");
    property p_end_sync; s_cal_end |-> sync_event && !cal_path_sel; endproperty
    a_end_sync: assert property (p_end_sync) else $error("no sync at cal end");
    property p_sync_one; sync_event |=> !sync_event; endproperty
    a_sync_one: assert property (p_sync_one) else $error("sync pulse too long");
    property p_cal_len; cal_busy |-> int'(tick_cnt_q) <= CAL_PFD_PERIODS + 1; endproperty
    a_cal_len: assert property (p_cal_len) else $error("cal runs too long");
    property p_fine; $past(resetn) |-> &ch_fine_ok; endproperty
    a_fine: assert property (p_fine) else $error("fine delay missing");
    property p_coarse; $past(resetn) |-> ch_coarse_ok == $past(route_ok); endproperty
    a_coarse: assert property (p_coarse) else $error("coarse enable wrong");
    property p_sync_ok; $past(resetn) |-> ch_sync_ok == $past(route_ok); endproperty
    a_sync_ok: assert property (p_sync_ok) else $error("sync enable wrong");
    property p_held;
        !done_q && (cal_busy || !busy_q) && $past(resetn) |->
            (ch_held & $past(synth_src)) == $past(synth_src);
    endproperty
    a_held: assert property (p_held) else $error("synth channel released early");
    property p_quiet; (ch_pulse & ch_held) == '0; endproperty
    a_quiet: assert property (p_quiet) else $error("held channel pulses");
    property p_cpole; lf_cpole1 <= CPOLE1_MAX; endproperty
    a_cpole: assert property (p_cpole) else $error("pole cap code out of range");
endmodule : sdvc_top_asserts

bind sdvc_top sdvc_top_asserts #(.CAL_PFD_PERIODS(CAL_PFD_PERIODS)) sdvc_top_asserts_i (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .ch_cfg(ch_cfg), .pfd_tick(pfd_tick),
    .fb_tick(fb_tick), .cal_path_sel(cal_path_sel), .cal_busy(cal_busy),
    .sync_event(sync_event), .lf_rzero(lf_rzero), .lf_cpole1(lf_cpole1), .lf_rpole2(lf_rpole2),
    .ch_pulse(ch_pulse), .ch_held(ch_held), .ch_coarse_ok(ch_coarse_ok),
    .ch_sync_ok(ch_sync_ok), .ch_fine_ok(ch_fine_ok));

/* File: testbench/sdvc_top_bench.sv */
// Self-checking bench for the synth divider and calibration block
`timescale 1ns/1ps
module sdvc_top_bench
    import sdvc_pkg::*;
;
    // ------------------------------------------------------------
    // Signals and design instance
    // ------------------------------------------------------------
    localparam int CALP = 100;
    logic clk, resetn, reg_we, reg_re, pfd_tick, fb_tick, cal_path_sel, cal_busy, sync_event;
    logic [ADDR_W-1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [2:0] lf_rzero, lf_cpole1;
    logic [1:0] lf_rpole2;
    sdvc_ch_cfg_t [NUM_CH-1:0] ch_cfg;
    logic [NUM_CH-1:0] ch_pulse, ch_held, ch_coarse_ok, ch_sync_ok, ch_fine_ok;
    logic [5:0] probe;
    int bad_count, comparisons;

    assign probe = {pfd_tick, fb_tick, ch_pulse[0], &ch_held, sync_event, cal_busy};

    sdvc_top #(.CAL_PFD_PERIODS(CALP)) sdvc_top_i (
        .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_re(reg_re), .reg_rdata(reg_rdata), .ch_cfg(ch_cfg), .pfd_tick(pfd_tick),
        .fb_tick(fb_tick), .cal_path_sel(cal_path_sel), .cal_busy(cal_busy),
        .sync_event(sync_event), .lf_rzero(lf_rzero), .lf_cpole1(lf_cpole1),
        .lf_rpole2(lf_rpole2), .ch_pulse(ch_pulse), .ch_held(ch_held),
        .ch_coarse_ok(ch_coarse_ok), .ch_sync_ok(ch_sync_ok), .ch_fine_ok(ch_fine_ok));

    always #12.5 clk = ~clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task summarize;
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask : wr

    task rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge clk);
        reg_re <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    // Samples 1 ns after each edge so registered outputs have settled
    task wait_probe(input int idx, input logic lvl, input int lim, output int n);
        for (n = 0; n < lim; n++) begin
            @(posedge clk);
            #1;
            if (probe[idx] === lvl) return;
        end
        bad_count++;
        $display("MISMATCH at %0t: wait on probe %0d ran out", $time, idx);
        summarize();
    endtask : wait_probe

    // The first interval after a commit may be short, so the third one is used
    task period(input int idx, output int p);
        int n;
        wait_probe(idx, 1'b1, 600, n);
        wait_probe(idx, 1'b1, 600, n);
        wait_probe(idx, 1'b1, 600, n);
        p = n + 1;
    endtask : period

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        check(16'(ch_fine_ok), 16'h3fff, "fine ok");
        check(16'(ch_coarse_ok), 16'h3feb, "coarse ok");
        check(16'(ch_sync_ok), 16'h3feb, "sync ok");
        check(16'(ch_held), 16'h0001, "held before cal");
        check(16'(ch_pulse[0]), 16'h0000, "held pulse");
    endtask : t_reset

    task t_dividers;
        logic [4:0] r1s [3] = '{5'h1f, 5'h01, 5'h03};
        int p;
        wr(ADDR_FB_B, 8'h0a);
        foreach (r1s[i]) begin
            wr(ADDR_FB_A, {3'h0, r1s[i]});
            wr(ADDR_COMMIT, 8'h01);
            period(5, p);
            check(16'(p), 16'(r1s[i]), "pfd period");
        end
        for (int m = 3; m <= 5; m++) begin
            wr(ADDR_FB_D, 8'(m));
            wr(ADDR_COMMIT, 8'h01);
            period(4, p);
            check(16'(p), 16'(10 * m), "fb period");
        end
        wr(ADDR_FB_D, 8'h03);
    endtask : t_dividers

    task t_regs;
        logic [7:0] d;
        wr(ADDR_FB_C, 8'h87);
        wr(ADDR_LF, 8'hbd);
        rd(ADDR_FB_C, d);
        check(16'(d), 16'h0087, "cal divider readback");
        rd(ADDR_LF, d);
        check(16'(d), 16'h00bd, "loop filter readback");
        rd(12'h300, d);
        check(16'(d), 16'h0000, "unmapped read");
        rd(ADDR_COMMIT, d);
        check(16'(d), 16'h0000, "commit read");
        wr(ADDR_COMMIT, 8'h01);
        repeat (2) @(posedge clk);
        #1;
        check(16'({lf_rpole2, lf_cpole1, lf_rzero}), 16'h00b5, "loop filter out");
    endtask : t_regs

    task t_cal;
        logic [7:0] d;
        int n, p;
        wr(ADDR_CAL, 8'h01);
        wr(ADDR_COMMIT, 8'h01);
        wait_probe(0, 1'b1, 10, n);
        check(16'(cal_path_sel), 16'h0001, "cal path on");
        rd(ADDR_STAT, d);
        check(16'(d), 16'h0005, "status busy");
        period(4, p);
        check(16'(p), 16'd30, "cal fb period");
        wait_probe(0, 1'b0, 400, n);
        check(16'({sync_event, cal_path_sel}), 16'h0002, "end of cal");
        rd(ADDR_STAT, d);
        check(16'(d), 16'h0002, "status done");
        wait_probe(3, 1'b1, 20, n);
        check(16'(ch_held[0]), 16'h0000, "released");
    endtask : t_cal

    task t_retrigger;
        int n;
        wr(ADDR_COMMIT, 8'h01);
        repeat (8) @(posedge clk);
        #1;
        check(16'(cal_busy), 16'h0000, "no restart while high");
        wr(ADDR_CAL, 8'h00);
        wr(ADDR_COMMIT, 8'h01);
        wr(ADDR_CAL, 8'h01);
        wr(ADDR_COMMIT, 8'h01);
        wait_probe(0, 1'b1, 10, n);
        wait_probe(0, 1'b0, 400, n);
        check(16'(n >= 3 * CALP - 4 && n <= 3 * CALP + 2), 16'h0001, "cal length");
    endtask : t_retrigger

    task t_sync;
        int n;
        wr(ADDR_SYNC, 8'h01);
        wait_probe(2, 1'b1, 3, n);
        check(16'(ch_pulse), 16'h0000, "outputs off in sync");
        wr(ADDR_SYNC, 8'h00);
        #1;
        check(16'(sync_event), 16'h0001, "sync on falling bit");
        @(posedge clk);
        #1;
        check(16'({sync_event, ch_held}), 16'h0000, "sync released");
        wait_probe(3, 1'b1, 4, n);
        check(16'(n), 16'h0000, "divider restarted by sync");
    endtask : t_sync

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_we = 1'b0;
        reg_re = 1'b0;
        bad_count = 0;
        comparisons = 0;
        for (int i = 0; i < NUM_CH; i++) begin
            ch_cfg[i] = '{src: SRC_CLEANUP, use_div: 1'b1, sysref_retime: 1'b0, div: 8'h04};
        end
        ch_cfg[0].src = SRC_SYNTH;
        ch_cfg[0].div = 8'h02;
        ch_cfg[2].src = SRC_SYSREF;
        ch_cfg[3].src = SRC_SYSREF;
        ch_cfg[3].sysref_retime = 1'b1;
        ch_cfg[4].use_div = 1'b0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        t_reset();
        t_dividers();
        t_regs();
        t_cal();
        t_retrigger();
        t_sync();
        summarize();
    end
endmodule : sdvc_top_bench
